/* File: core/eie_pkg.sv */
package eie_pkg;

   // Escape prefix and second-byte opcodes.
   localparam logic [7:0] PREFIX_BYTE = 8'ha5;
   localparam logic [7:0] OP_BREAK = 8'h00;
   localparam logic [7:0] OP_ASR = 8'h03;
   localparam logic [7:0] OP_LSL = 8'h23;
   localparam logic [7:0] OP_CLR_MACC = 8'h43;
   localparam logic [7:0] OP_JMP_APC = 8'h73;
   localparam logic [7:0] OP_MOV_ALT = 8'h90;
   localparam logic [7:0] OP_CODE_BYTE_LOAD_ALT = 8'h93;
   localparam logic [7:0] OP_INC_ALT = 8'ha3;
   localparam logic [7:0] OP_MAC = 8'ha4;
   localparam logic [7:0] OP_COMPARE_JUMP_UNEQUAL_R0 = 8'hb6;
   localparam logic [7:0] OP_COMPARE_JUMP_UNEQUAL_R1 = 8'hb7;
   localparam logic [7:0] OP_EXTERNAL_MOVE_RD = 8'he0;

   // Instruction lengths in clock cycles, prefix cycle included.
   localparam logic [3:0] CYC_SHORT = 4'h2;
   localparam logic [3:0] CYC_INC = 4'h3;
   localparam logic [3:0] CYC_JMP = 4'h3;
   localparam logic [3:0] CYC_COMPARE_JUMP_UNEQUAL = 4'h4;
   localparam logic [3:0] CYC_CODE_BYTE_LOAD = 4'h4;
   localparam logic [3:0] CYC_MOV_ALT = 4'h4;
   localparam logic [3:0] CYC_MAC = 4'h9;
   localparam logic [3:0] CYC_EXTERNAL_MOVE_ERAM = 4'h3;
   localparam logic [3:0] CYC_EXTERNAL_MOVE_EXT = 4'h5;

   // Register byte offsets.
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_FIRST_DATA_POINTER = 8'h04;
   localparam logic [7:0] ADDR_SECOND_DATA_POINTER = 8'h08;
   localparam logic [7:0] ADDR_OPHI = 8'h0c;
   localparam logic [7:0] ADDR_MACC_LO = 8'h10;
   localparam logic [7:0] ADDR_MACC_HI = 8'h14;
   localparam logic [7:0] ADDR_STATUS = 8'h18;

   // Register field positions and reset values.
   localparam int CTRL_DPS_BIT = 0;
   localparam int CTRL_DBG_BIT = 1;
   localparam int CTRL_FAST_BIT = 2;
   localparam int CTRL_FLASH_DATA_SPACE_BIT = 3;
   localparam int CTRL_WS_LSB = 4;
   localparam int OPHI_BX_LSB = 8;
   localparam int STATUS_OP_LSB = 8;
   localparam logic [6:0] CTRL_RST = 7'h04;
   localparam logic [15:0] DPTR_RST = 16'h0000;
   localparam logic [7:0] OPHI_RST = 8'h00;
   localparam logic [39:0] MACC_RST = 40'h00_0000_0000;

   typedef enum logic [2:0] {SP_CODE, SP_IRAM, SP_ERAM, SP_FLASH_DATA_SPACE, SP_EXTERNAL_DATA_SPACE} eie_space_e;

   typedef struct packed {
      logic rd;
      eie_space_e space;
      logic [15:0] addr;
   } eie_memreq_s;

   typedef struct packed {
      logic pc_load;
      logic [15:0] pc;
      logic acc_we;
      logic [7:0] acc;
      logic cy_we;
      logic cy;
      logic ov_set;
      logic brk;
   } eie_result_s;

endpackage

/* File: core/eie_mac_unit.sv */
`timescale 1ns/1ps
module eie_mac_unit (
   // Operands
   input wire logic [39:0] macc_in,
   input wire logic [7:0] a_lo,
   input wire logic [7:0] a_hi,
   input wire logic [7:0] b_lo,
   input wire logic [7:0] b_hi,
   // Result
   output logic [39:0] sum,
   output logic ovf
);
   logic signed [31:0] prod;
   logic [39:0] prod_ext;

   always_comb begin
      prod = $signed({a_hi, a_lo}) * $signed({b_hi, b_lo});
      prod_ext = {{8{prod[31]}}, prod};
      sum = macc_in + prod_ext;
      // Overflow only when both addends share a sign the sum lost.
      ovf = (macc_in[39] == prod_ext[39]) && (sum[39] != macc_in[39]);
   end
endmodule

/* File: core/eie_decoder.sv */
`timescale 1ns/1ps
// Contract
// - Escape byte prefixes every extension, then opcode
// - Arithmetic right shift keeps bit 39
// - Logical left shift loads zero bit
// - Clear zeroes whole multiply accumulator
// - Breakpoint enters debug, PC after it
// - Breakpoint without debug is two-cycle nop
// - Compare indirect, branch relative when unequal
// - Carry means accumulator below byte, unsigned
// - Increment the unselected data pointer
// - Jump to accumulator plus PC+2
// - Code byte load via unselected pointer
// - Signed 16x16 product added to accumulator
// - Overflow sticky set, carry holds sign
// - Immediate load of unselected pointer, high first
// - External read via unselected pointer
// - Each wait state adds one cycle, external data space with fast bit set only
module eie_decoder #(
   parameter logic [15:0] ERAM_LIMIT = 16'h0400
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic RESET,
   // Register bus
   input wire logic [7:0] PADDR,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Instruction bytes and core state
   input wire logic FETCH_VALID,
   input wire logic [7:0] FETCH_BYTE,
   input wire logic [15:0] PC_CUR,
   input wire logic [7:0] ACC_IN,
   input wire logic [7:0] B_IN,
   input wire logic [7:0] R0_IN,
   input wire logic [7:0] R1_IN,
   // Data memory
   output eie_pkg::eie_memreq_s MEM_REQ,
   input wire logic [7:0] MEM_RDATA,
   // Results to the core
   output eie_pkg::eie_result_s RESULT,
   output logic DONE,
   output logic BUSY
);
   typedef enum logic [1:0] {ST_IDLE, ST_OPCODE, ST_RUN} eie_state_e;

   eie_state_e state_reg;
   logic [3:0] cnt_reg;
   logic [7:0] op_reg;
   logic [15:0] pc_reg;
   logic [1:0] got_reg;
   logic [7:0] b1_reg, b2_reg, mdata_reg;
   logic mgot_reg;
   eie_pkg::eie_space_e space_reg;
   eie_pkg::eie_memreq_s mem_reg;
   eie_pkg::eie_result_s res_reg, res_next;
   logic done_reg;
   logic [6:0] ctrl_reg;
   logic [15:0] first_data_pointer_reg, second_data_pointer_reg;
   logic [7:0] ax_reg, bx_reg;
   logic [39:0] macc_reg;
   logic [31:0] prdata_reg;

   logic [7:0] cur_op, b1_next, b2_next, mdata_next;
   logic [1:0] need, got_next;
   logic [3:0] cyc;
   logic take_byte, needs_mem, mready, finish, prefix_seen;
   logic pointer_select, dbg_en, fast_en;
   logic [1:0] wait_states;
   logic [15:0] alt_dp, pc_two, pc_three;
   logic [39:0] mac_sum;
   logic mac_ovf;
   logic apb_wr, apb_hit;

   assign pointer_select = ctrl_reg[eie_pkg::CTRL_DPS_BIT];
   assign dbg_en = ctrl_reg[eie_pkg::CTRL_DBG_BIT];
   assign fast_en = ctrl_reg[eie_pkg::CTRL_FAST_BIT];
   assign wait_states = ctrl_reg[eie_pkg::CTRL_WS_LSB +: 2];
   assign alt_dp = pointer_select ? first_data_pointer_reg : second_data_pointer_reg;

   eie_mac_unit u_mac (
      .macc_in(macc_reg),
      .a_lo(ACC_IN),
      .a_hi(ax_reg),
      .b_lo(B_IN),
      .b_hi(bx_reg),
      .sum(mac_sum),
      .ovf(mac_ovf)
   );

   // Escape bytes start an instruction only in ST_IDLE; while busy they are taken as opcode, operand or filler.
   assign prefix_seen = (state_reg == ST_IDLE) && FETCH_VALID
      && (FETCH_BYTE == eie_pkg::PREFIX_BYTE);
   assign cur_op = (state_reg == ST_OPCODE) ? FETCH_BYTE : op_reg;

   always_comb begin
      need = 2'd0;
      needs_mem = 1'b0;
      cyc = eie_pkg::CYC_SHORT;
      case (cur_op)
         eie_pkg::OP_INC_ALT: cyc = eie_pkg::CYC_INC;
         eie_pkg::OP_JMP_APC: cyc = eie_pkg::CYC_JMP;
         eie_pkg::OP_MAC: cyc = eie_pkg::CYC_MAC;
         eie_pkg::OP_CODE_BYTE_LOAD_ALT: begin
            cyc = eie_pkg::CYC_CODE_BYTE_LOAD;
            needs_mem = 1'b1;
         end
         eie_pkg::OP_MOV_ALT: begin
            cyc = eie_pkg::CYC_MOV_ALT;
            need = 2'd2;
         end
         eie_pkg::OP_COMPARE_JUMP_UNEQUAL_R0, eie_pkg::OP_COMPARE_JUMP_UNEQUAL_R1: begin
            cyc = eie_pkg::CYC_COMPARE_JUMP_UNEQUAL;
            need = 2'd1;
            needs_mem = 1'b1;
         end
         eie_pkg::OP_EXTERNAL_MOVE_RD: begin
            needs_mem = 1'b1;
            if (space_reg == eie_pkg::SP_ERAM) begin
               cyc = eie_pkg::CYC_EXTERNAL_MOVE_ERAM;
            end else if (fast_en && space_reg == eie_pkg::SP_EXTERNAL_DATA_SPACE) begin
               cyc = eie_pkg::CYC_EXTERNAL_MOVE_EXT + {2'b00, wait_states};
            end else begin
               cyc = eie_pkg::CYC_EXTERNAL_MOVE_EXT;
            end
         end
         default: cyc = eie_pkg::CYC_SHORT;
      endcase
   end

   always_comb begin
      take_byte = FETCH_VALID && (state_reg == ST_RUN) && (got_reg < need);
      b1_next = (take_byte && got_reg == 2'd0) ? FETCH_BYTE : b1_reg;
      b2_next = (take_byte && got_reg == 2'd1) ? FETCH_BYTE : b2_reg;
      got_next = take_byte ? got_reg + 2'd1 : got_reg;
      // Memory answers in the cycle its request is shown.
      mdata_next = mem_reg.rd ? MEM_RDATA : mdata_reg;
      mready = !needs_mem || mgot_reg || mem_reg.rd;
      finish = ((state_reg == ST_OPCODE && FETCH_VALID) || state_reg == ST_RUN)
         && (cnt_reg >= cyc - 4'd1) && (got_next == need) && mready;
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         state_reg <= ST_IDLE;
         cnt_reg <= 4'h0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (prefix_seen) begin
                  state_reg <= ST_OPCODE;
                  cnt_reg <= 4'h1;
               end
            end
            ST_OPCODE: begin
               if (FETCH_VALID) begin
                  state_reg <= finish ? ST_IDLE : ST_RUN;
                  cnt_reg <= 4'h2;
               end
            end
            ST_RUN: begin
               if (finish) begin
                  state_reg <= ST_IDLE;
               end else if (cnt_reg != 4'hf) begin
                  cnt_reg <= cnt_reg + 4'h1;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // Instruction context: pc, opcode, operand bytes and memory data.
   always_ff @(posedge CLK) begin
      if (RESET) begin
         op_reg <= 8'h00;
         pc_reg <= 16'h0000;
         got_reg <= 2'd0;
         b1_reg <= 8'h00;
         b2_reg <= 8'h00;
         mdata_reg <= 8'h00;
         mgot_reg <= 1'b0;
      end else begin
         if (prefix_seen) begin
            pc_reg <= PC_CUR;
            got_reg <= 2'd0;
            mgot_reg <= 1'b0;
         end else begin
            got_reg <= got_next;
            mgot_reg <= mgot_reg || mem_reg.rd;
         end
         if (state_reg == ST_OPCODE && FETCH_VALID) begin
            op_reg <= FETCH_BYTE;
         end
         b1_reg <= b1_next;
         b2_reg <= b2_next;
         mdata_reg <= mdata_next;
      end
   end

   // One-cycle memory request issued when the opcode is taken.
   always_ff @(posedge CLK) begin
      if (RESET) begin
         mem_reg <= '0;
         space_reg <= eie_pkg::SP_CODE;
      end else begin
         mem_reg.rd <= 1'b0;
         if (state_reg == ST_OPCODE && FETCH_VALID && needs_mem) begin
            mem_reg.rd <= 1'b1;
            if (cur_op == eie_pkg::OP_CODE_BYTE_LOAD_ALT) begin
               mem_reg.space <= eie_pkg::SP_CODE;
               mem_reg.addr <= alt_dp + {8'h00, ACC_IN};
               space_reg <= eie_pkg::SP_CODE;
            end else if (cur_op == eie_pkg::OP_EXTERNAL_MOVE_RD) begin
               mem_reg.addr <= alt_dp;
               if (alt_dp < ERAM_LIMIT) begin
                  mem_reg.space <= eie_pkg::SP_ERAM;
                  space_reg <= eie_pkg::SP_ERAM;
               end else if (ctrl_reg[eie_pkg::CTRL_FLASH_DATA_SPACE_BIT]) begin
                  mem_reg.space <= eie_pkg::SP_FLASH_DATA_SPACE;
                  space_reg <= eie_pkg::SP_FLASH_DATA_SPACE;
               end else begin
                  mem_reg.space <= eie_pkg::SP_EXTERNAL_DATA_SPACE;
                  space_reg <= eie_pkg::SP_EXTERNAL_DATA_SPACE;
               end
            end else begin
               mem_reg.space <= eie_pkg::SP_IRAM;
               mem_reg.addr <= {8'h00, cur_op[0] ? R1_IN : R0_IN};
               space_reg <= eie_pkg::SP_IRAM;
            end
         end
      end
   end

   assign pc_two = pc_reg + 16'h0002;
   assign pc_three = pc_reg + 16'h0003;

   always_comb begin
      res_next = '0;
      res_next.pc_load = 1'b1;
      res_next.pc = pc_two;
      case (cur_op)
         eie_pkg::OP_BREAK: res_next.brk = dbg_en;
         eie_pkg::OP_JMP_APC: res_next.pc = pc_two + {8'h00, ACC_IN};
         eie_pkg::OP_MOV_ALT: res_next.pc = pc_reg + 16'h0004;
         eie_pkg::OP_CODE_BYTE_LOAD_ALT, eie_pkg::OP_EXTERNAL_MOVE_RD: begin
            res_next.acc_we = 1'b1;
            res_next.acc = mdata_next;
         end
         eie_pkg::OP_COMPARE_JUMP_UNEQUAL_R0, eie_pkg::OP_COMPARE_JUMP_UNEQUAL_R1: begin
            res_next.pc = pc_three;
            if (ACC_IN != mdata_next) begin
               res_next.pc = pc_three + {{8{b1_next[7]}}, b1_next};
            end
            res_next.cy_we = 1'b1;
            res_next.cy = ACC_IN < mdata_next;
         end
         eie_pkg::OP_MAC: begin
            res_next.ov_set = mac_ovf;
            res_next.cy_we = 1'b1;
            res_next.cy = mac_sum[39];
         end
         default: res_next.pc = pc_two;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         res_reg <= '0;
         done_reg <= 1'b0;
      end else begin
         done_reg <= finish;
         res_reg <= finish ? res_next : '0;
      end
   end

   assign apb_wr = PSEL && PENABLE && PWRITE;
   always_comb begin
      case (PADDR)
         eie_pkg::ADDR_CTRL, eie_pkg::ADDR_FIRST_DATA_POINTER, eie_pkg::ADDR_SECOND_DATA_POINTER,
         eie_pkg::ADDR_OPHI, eie_pkg::ADDR_MACC_LO, eie_pkg::ADDR_MACC_HI,
         eie_pkg::ADDR_STATUS: apb_hit = 1'b1;
         default: apb_hit = 1'b0;
      endcase
   end

   // Multiply accumulator; a finishing instruction wins over a bus write.
   always_ff @(posedge CLK) begin
      if (RESET) begin
         macc_reg <= eie_pkg::MACC_RST;
      end else if (finish && cur_op == eie_pkg::OP_ASR) begin
         macc_reg <= {macc_reg[39], macc_reg[39:1]};
      end else if (finish && cur_op == eie_pkg::OP_LSL) begin
         macc_reg <= {macc_reg[38:0], 1'b0};
      end else if (finish && cur_op == eie_pkg::OP_CLR_MACC) begin
         macc_reg <= eie_pkg::MACC_RST;
      end else if (finish && cur_op == eie_pkg::OP_MAC) begin
         macc_reg <= mac_sum;
      end else if (apb_wr && PADDR == eie_pkg::ADDR_MACC_LO) begin
         macc_reg[31:0] <= PWDATA;
      end else if (apb_wr && PADDR == eie_pkg::ADDR_MACC_HI) begin
         macc_reg[39:32] <= PWDATA[7:0];
      end
   end

   // Data pointers.
   always_ff @(posedge CLK) begin
      if (RESET) begin
         first_data_pointer_reg <= eie_pkg::DPTR_RST;
         second_data_pointer_reg <= eie_pkg::DPTR_RST;
      end else if (finish && cur_op == eie_pkg::OP_INC_ALT) begin
         if (pointer_select) begin
            first_data_pointer_reg <= first_data_pointer_reg + 16'h0001;
         end else begin
            second_data_pointer_reg <= second_data_pointer_reg + 16'h0001;
         end
      end else if (finish && cur_op == eie_pkg::OP_MOV_ALT) begin
         if (pointer_select) begin
            first_data_pointer_reg <= {b1_next, b2_next};
         end else begin
            second_data_pointer_reg <= {b1_next, b2_next};
         end
      end else if (apb_wr && PADDR == eie_pkg::ADDR_FIRST_DATA_POINTER) begin
         first_data_pointer_reg <= PWDATA[15:0];
      end else if (apb_wr && PADDR == eie_pkg::ADDR_SECOND_DATA_POINTER) begin
         second_data_pointer_reg <= PWDATA[15:0];
      end
   end

   // Control and high operand bytes are software owned.
   always_ff @(posedge CLK) begin
      if (RESET) begin
         ctrl_reg <= eie_pkg::CTRL_RST;
         ax_reg <= eie_pkg::OPHI_RST;
         bx_reg <= eie_pkg::OPHI_RST;
      end else if (apb_wr && PADDR == eie_pkg::ADDR_CTRL) begin
         ctrl_reg <= PWDATA[6:0];
      end else if (apb_wr && PADDR == eie_pkg::ADDR_OPHI) begin
         ax_reg <= PWDATA[7:0];
         bx_reg <= PWDATA[eie_pkg::OPHI_BX_LSB +: 8];
      end
   end

   // Read data is latched in the setup phase, so the slave never stalls.
   always_ff @(posedge CLK) begin
      if (RESET) begin
         prdata_reg <= 32'h0000_0000;
      end else if (PSEL && !PENABLE) begin
         case (PADDR)
            eie_pkg::ADDR_CTRL: prdata_reg <= {25'h0, ctrl_reg};
            eie_pkg::ADDR_FIRST_DATA_POINTER: prdata_reg <= {16'h0000, first_data_pointer_reg};
            eie_pkg::ADDR_SECOND_DATA_POINTER: prdata_reg <= {16'h0000, second_data_pointer_reg};
            eie_pkg::ADDR_OPHI: prdata_reg <= {16'h0000, bx_reg, ax_reg};
            eie_pkg::ADDR_MACC_LO: prdata_reg <= macc_reg[31:0];
            eie_pkg::ADDR_MACC_HI: prdata_reg <= {24'h000000, macc_reg[39:32]};
            eie_pkg::ADDR_STATUS: prdata_reg <= {16'h0000, op_reg, 7'h00, BUSY};
            default: prdata_reg <= 32'h0000_0000;
         endcase
      end
   end

   assign PRDATA = prdata_reg;
   assign PREADY = 1'b1;
   assign PSLVERR = PSEL && PENABLE && !apb_hit;
   assign MEM_REQ = mem_reg;
   assign RESULT = res_reg;
   assign DONE = done_reg;
   assign BUSY = state_reg != ST_IDLE;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);

   chk_prefix_start: assert property (prefix_seen |=> state_reg == ST_OPCODE)
      else $error("escape byte not taken as prefix");
   chk_asr_sign: assert property (finish && cur_op == eie_pkg::OP_ASR |=>
      macc_reg[39:38] == {2{$past(macc_reg[39])}} && macc_reg[37:0] == $past(macc_reg[38:1]))
      else $error("arithmetic shift wrong");
   chk_lsl_zero: assert property (finish && cur_op == eie_pkg::OP_LSL |=>
      macc_reg == {$past(macc_reg[38:0]), 1'b0} && !RESULT.cy_we)
      else $error("logical shift wrong");
   chk_clr_macc: assert property (finish && cur_op == eie_pkg::OP_CLR_MACC |=>
      macc_reg == 40'h00_0000_0000 && !RESULT.cy_we && !RESULT.ov_set)
      else $error("clear did not zero accumulator");
   chk_break_pc: assert property (finish && cur_op == eie_pkg::OP_BREAK |=>
      RESULT.brk == $past(dbg_en) && RESULT.pc == $past(pc_reg) + 16'h0002)
      else $error("breakpoint result wrong");
   chk_short_len: assert property (prefix_seen ##1 FETCH_VALID &&
      (FETCH_BYTE == eie_pkg::OP_BREAK || FETCH_BYTE == 8'h01) |=> DONE && state_reg == ST_IDLE)
      else $error("two-cycle instruction overran");
   chk_compare_jump_unequal_carry: assert property (finish && cur_op[7:1] == 7'h5b |=>
      RESULT.cy_we && RESULT.cy == ($past(ACC_IN) < $past(mdata_next)))
      else $error("compare carry wrong");
   chk_inc_alt: assert property (finish && cur_op == eie_pkg::OP_INC_ALT && !pointer_select |=>
      second_data_pointer_reg == $past(second_data_pointer_reg) + 16'h0001 && $stable(first_data_pointer_reg))
      else $error("alternate increment wrong");
   chk_jmp_target: assert property (finish && cur_op == eie_pkg::OP_JMP_APC |=>
      RESULT.pc == $past(pc_reg) + 16'h0002 + {8'h00, $past(ACC_IN)})
      else $error("indirect jump target wrong");
   chk_external_move_wait: assert property (finish && cur_op == eie_pkg::OP_EXTERNAL_MOVE_RD && fast_en
      && space_reg == eie_pkg::SP_EXTERNAL_DATA_SPACE |-> cnt_reg == 4'h4 + {2'b00, wait_states})
      else $error("external move length wrong");
   chk_unknown_safe: assert property (finish && cur_op == 8'hff |=>
      $stable(macc_reg) && $stable(first_data_pointer_reg) && $stable(second_data_pointer_reg) && !RESULT.acc_we)
      else $error("unknown opcode changed state");

   cov_break_dbg: cover property (finish && cur_op == eie_pkg::OP_BREAK && dbg_en);
   cov_mac_ovf: cover property (finish && cur_op == eie_pkg::OP_MAC && mac_ovf);
   cov_external_move_wait: cover property (finish && cur_op == eie_pkg::OP_EXTERNAL_MOVE_RD && wait_states == 2'd3);
   cov_compare_jump_unequal_taken: cover property (finish && cur_op[7:1] == 7'h5b && ACC_IN != mdata_next);
endmodule

/* File: dv/eie_mem_model.sv */
`timescale 1ns/1ps
module eie_mem_model (
   // Clock
   input wire logic clk,
   // Request and answer
   input wire eie_pkg::eie_memreq_s mem_req,
   output logic [7:0] mem_rdata
);
   logic [7:0] idle_q = 8'h5a;

   // The read is asynchronous, so data is valid only while rd is high.
   // Outside a read the bus toggles every cycle so stale data never matches.
   always @(posedge clk) begin
      idle_q <= ~idle_q;
   end

   always_comb begin
      if (mem_req.rd) begin
         mem_rdata = mem_req.addr[7:0] ^ mem_req.addr[15:8] ^ {5'h00, mem_req.space};
      end else begin
         mem_rdata = idle_q;
      end
   end
endmodule

/* File: dv/test_escaped_instruction_extensions.sv */
`timescale 1ns/1ps
module test_escaped_instruction_extensions;
   logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, fv = 0, done, busy, prdy, perr, err;
   logic [7:0] paddr = 8'h00, fb = 8'h00, acc = 8'h00, b = 8'h00, r0 = 8'h00, r1 = 8'h00;
   logic [7:0] mrd, op, x, y, ea, mv, ah, bh;
   logic [31:0] pwd = 32'h0, prd, rd, lo;
   logic [15:0] pc = 16'h0, dp0, dp1, alt, epc;
   logic [39:0] m;
   logic [5:0] ctrl;
   logic [2:0] sp;
   logic awe, cwe, ecy, eov, brk;
   longint s;
   int mismatches = 0, comparisons = 0, cyc = 0, n, nexp, len;
   logic [7:0] bs[$];
   logic [7:0] opl[13] = '{8'h00, 8'h03, 8'h23, 8'h43, 8'h73, 8'h90, 8'h93, 8'ha3, 8'ha4,
      8'hb6, 8'hb7, 8'he0, 8'h11};
   eie_pkg::eie_memreq_s mreq;
   eie_pkg::eie_result_s res, got;

   eie_decoder dut_u (.CLK(clk), .RESET(rst), .PADDR(paddr), .PSEL(psel), .PENABLE(pen),
      .PWRITE(pwr), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr),
      .FETCH_VALID(fv), .FETCH_BYTE(fb), .PC_CUR(pc), .ACC_IN(acc), .B_IN(b), .R0_IN(r0),
      .R1_IN(r1), .MEM_REQ(mreq), .MEM_RDATA(mrd), .RESULT(res), .DONE(done), .BUSY(busy));
   eie_mem_model mem_u (.clk(clk), .mem_req(mreq), .mem_rdata(mrd));

   initial begin
      forever #20 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         mismatches++;
         finish_test();
      end
   end

   function automatic logic [7:0] mdat(logic [2:0] sp_i, logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ {5'h00, sp_i};
   endfunction

   task automatic chk(string nm, logic [39:0] e, logic [39:0] g);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
      @(posedge clk);
      psel <= 1;
      pen <= 0;
      pwr <= w;
      paddr <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1;
      do @(posedge clk); while (prdy !== 1'b1);
      rd = prd;
      err = perr;
      psel <= 0;
      pen <= 0;
   endtask

   // Bytes go out back to back; the cycle count starts at the prefix cycle.
   task automatic run();
      @(posedge clk);
      fv <= 1;
      fb <= bs[0];
      n = 0;
      do begin
         @(posedge clk);
         n++;
         fb <= n < bs.size() ? bs[n] : 8'($urandom);
         fv <= n < bs.size();
         #1;
         if (done !== 1'b1) chk("busy", 40'h01, 40'(busy));
      end while (done !== 1'b1);
      got = res;
   endtask

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      void'($urandom(94566));
      repeat (16) @(posedge clk);
      rst <= 0;
      apb(0, eie_pkg::ADDR_CTRL, 32'h0);
      chk("ctrl", 40'(eie_pkg::CTRL_RST), 40'(rd));
      apb(0, 8'h40, 32'h0);
      chk("unmapped", 40'h01_0000_0000, 40'({err, rd}));
      for (int i = 0; i < 200; i++) begin
         ctrl = 6'($urandom);
         dp0 = 16'($urandom) & ($urandom_range(1) ? 16'h07ff : 16'hffff);
         dp1 = 16'($urandom) & ($urandom_range(1) ? 16'h07ff : 16'hffff);
         {ah, bh} = 16'($urandom);
         m = {8'($urandom), 32'($urandom)};
         apb(1, eie_pkg::ADDR_CTRL, {26'h0, ctrl});
         apb(1, eie_pkg::ADDR_FIRST_DATA_POINTER, {16'h0, dp0});
         apb(1, eie_pkg::ADDR_SECOND_DATA_POINTER, {16'h0, dp1});
         apb(1, eie_pkg::ADDR_OPHI, {16'h0, bh, ah});
         apb(1, eie_pkg::ADDR_MACC_LO, m[31:0]);
         apb(1, eie_pkg::ADDR_MACC_HI, {24'h0, m[39:32]});
         acc <= 8'($urandom);
         b <= 8'($urandom);
         r0 <= 8'($urandom);
         r1 <= 8'($urandom);
         pc <= 16'($urandom);
         // Half of the spare picks use an opcode that is known to be unused.
         opl[12] = $urandom_range(1) ? 8'hff : 8'($urandom);
         op = opl[$urandom_range(12)];
         x = 8'($urandom);
         y = 8'($urandom);
         len = op == 8'h90 ? 4 : (op == 8'hb6 || op == 8'hb7) ? 3 : 2;
         bs = {8'ha5, op, x, y};
         bs = bs[0:len-1];
         run();
         alt = ctrl[0] ? dp0 : dp1;
         epc = pc + 16'h0002;
         {awe, cwe, ecy, eov, brk, ea} = '0;
         nexp = 2;
         case (op)
            8'h00: brk = ctrl[1];
            8'h03: m = {m[39], m[39:1]};
            8'h23: m = {m[38:0], 1'b0};
            8'h43: m = '0;
            8'h73: begin
               epc = pc + 16'h0002 + {8'h00, acc};
               nexp = 3;
            end
            8'h90: begin
               alt = {x, y};
               epc = pc + 16'h0004;
               nexp = 4;
            end
            8'h93: begin
               awe = 1;
               ea = mdat(3'h0, alt + {8'h00, acc});
               nexp = 4;
            end
            8'ha3: begin
               alt++;
               nexp = 3;
            end
            8'ha4: begin
               s = longint'($signed(m)) + int'($signed({ah, acc})) * int'($signed({bh, b}));
               eov = s != longint'($signed(40'(s)));
               m = 40'(s);
               cwe = 1;
               ecy = m[39];
               nexp = 9;
            end
            8'hb6, 8'hb7: begin
               mv = mdat(3'h1, {8'h00, op[0] ? r1 : r0});
               cwe = 1;
               ecy = acc < mv;
               epc = pc + 16'h0003 + (acc != mv ? {{8{x[7]}}, x} : 16'h0000);
               nexp = 4;
            end
            8'he0: begin
               awe = 1;
               sp = alt < 16'h0400 ? 3'h2 : ctrl[3] ? 3'h3 : 3'h4;
               ea = mdat(sp, alt);
               nexp = sp == 3'h2 ? 3 : 5 + (sp == 3'h4 && ctrl[2] ? int'(ctrl[5:4]) : 0);
            end
            default: ;
         endcase
         if (ctrl[0]) dp0 = alt;
         else dp1 = alt;
         chk("cycles", 40'(nexp), 40'(n));
         chk("pc", {23'h0, 1'b1, epc}, {23'h0, got.pc_load, got.pc});
         chk("acc", {31'h0, awe, ea}, {31'h0, got.acc_we, awe ? got.acc : 8'h00});
         chk("flags", {36'h0, cwe, ecy, eov, brk},
            {36'h0, got.cy_we, cwe & got.cy, got.ov_set, got.brk});
         apb(0, eie_pkg::ADDR_STATUS, 32'h0);
         chk("status", {24'h0, op, 8'h00}, 40'(rd));
         apb(0, eie_pkg::ADDR_FIRST_DATA_POINTER, 32'h0);
         chk("first_data_pointer", 40'(dp0), 40'(rd));
         apb(0, eie_pkg::ADDR_SECOND_DATA_POINTER, 32'h0);
         chk("second_data_pointer", 40'(dp1), 40'(rd));
         apb(0, eie_pkg::ADDR_OPHI, 32'h0);
         chk("ophi", {24'h0, bh, ah}, 40'(rd));
         apb(0, eie_pkg::ADDR_MACC_LO, 32'h0);
         lo = rd;
         apb(0, eie_pkg::ADDR_MACC_HI, 32'h0);
         chk("macc", m, {rd[7:0], lo});
      end
      finish_test();
   end
endmodule
